/* aeil_host.sv */
// host model: drives register requests and collects read data
// assumes the design's registered read port on ref_clk
`timescale 1ns/1ns
module aeil_host
   import aeil_pkg::*;
(
   input wire logic ref_clk,
   input wire logic [7:0] reg_rdata_q,
   output aeil_req_t reg_req
);
   initial begin
      reg_req = '0;
   end
   // one-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge ref_clk);
      reg_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: v};
      @(negedge ref_clk);
      reg_req = '0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge ref_clk);
      reg_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(negedge ref_clk);
      reg_req = '0;
      v = reg_rdata_q;
   endtask
endmodule

/* aeil_pkg.sv */
// constants and types for the audio event interrupt logic
// assumes a single 25 MHz clock; event sources arrive on that clock
package aeil_pkg;

   // ************************************************************
   // register offsets
   // ************************************************************
   localparam logic [7:0] AEIL_STAT1_ADDR = 8'h07;
   localparam logic [7:0] AEIL_STAT2_ADDR = 8'h08;
   localparam logic [7:0] AEIL_MASK1_ADDR = 8'h09;
   localparam logic [7:0] AEIL_MODE1_HI_ADDR = 8'h0A;
   localparam logic [7:0] AEIL_MODE1_LO_ADDR = 8'h0B;
   localparam logic [7:0] AEIL_MASK2_ADDR = 8'h0C;
   localparam logic [7:0] AEIL_MODE2_HI_ADDR = 8'h0D;
   localparam logic [7:0] AEIL_MODE2_LO_ADDR = 8'h0E;

   // ************************************************************
   // reset values and field layout
   // ************************************************************
   localparam logic [7:0] AEIL_REG_RESET = 8'h00;
   localparam logic [7:0] AEIL_UNMAPPED_READ = 8'h00;
   localparam logic [7:0] AEIL_SET2_USED = 8'h3F;
   localparam int AEIL_TX_SLIP_BIT = 7;
   localparam int AEIL_OUT_SLIP_BIT = 6;
   localparam int AEIL_RANGE_BIT = 5;
   localparam int AEIL_OVRL_BIT = 4;
   localparam int AEIL_OVRR_BIT = 3;
   localparam int AEIL_CDE_BIT = 2;
   localparam int AEIL_CEF_BIT = 1;
   localparam int AEIL_RFLT_BIT = 0;

   // ************************************************************
   // ratio figures
   // ************************************************************
   localparam logic [9:0] AEIL_RATIO_256 = 10'h100;
   localparam logic [9:0] AEIL_RATIO_384 = 10'h180;
   localparam logic [9:0] AEIL_RATIO_512 = 10'h200;
   localparam logic [9:0] AEIL_RATIO_NONE = 10'h000;
   localparam logic [9:0] AEIL_COUNT_MAX = 10'h3FF;
   localparam logic [1:0] AEIL_RANGE_LIMIT = 2'h3;

   typedef enum logic [1:0] {
      AEIL_TRIG_RISE = 2'b00,
      AEIL_TRIG_FALL = 2'b01,
      AEIL_TRIG_LEVEL = 2'b10,
      AEIL_TRIG_RSVD = 2'b11
   } aeil_trig_t;

   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } aeil_req_t;

endpackage

/* aeil_ratio_check.sv */
// counts master clock ticks per frame and flags a mismatch with the selection
// assumes both ticks are one-cycle enables on ref_clk
`timescale 1ns/1ns
module aeil_ratio_check
   import aeil_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic check_en,
   input wire logic master_tick,
   input wire logic frame_tick,
   input wire logic [1:0] master_ratio_select,
   output logic mismatch_q
);

   logic [9:0] count_q;
   logic armed_q;
   logic [9:0] expect_cnt;

   function automatic logic [9:0] ratio_of(input logic [1:0] sel);
      case (sel)
         2'h0: ratio_of = AEIL_RATIO_256;
         2'h1: ratio_of = AEIL_RATIO_384;
         2'h2: ratio_of = AEIL_RATIO_512;
         default: ratio_of = AEIL_RATIO_NONE;
      endcase
   endfunction

   assign expect_cnt = ratio_of(master_ratio_select);

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         count_q <= AEIL_RATIO_NONE;
      end else if (frame_tick) begin
         count_q <= {9'h000, master_tick};
      end else if (master_tick && count_q != AEIL_COUNT_MAX) begin
         count_q <= count_q + 10'h001;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         armed_q <= 1'b0;
      end else if (!check_en) begin
         armed_q <= 1'b0;
      end else if (frame_tick) begin
         armed_q <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         mismatch_q <= 1'b0;
      end else begin
         mismatch_q <= check_en & armed_q & frame_tick & (expect_cnt != AEIL_RATIO_NONE)
                       & (count_q != expect_cnt);
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   ratio_after_frame_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      mismatch_q |-> $past(frame_tick) && $past(check_en))
      else $error("ratio mismatch without a frame boundary");

endmodule

/* aeil_status_reg.sv */
// one 8-bit sticky status register with mask and 2-bit trigger modes
// assumes sources and the read-clear strobe are on ref_clk
`timescale 1ns/1ns
module aeil_status_reg
   import aeil_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [7:0] src,
   input wire logic [7:0] mask,
   input wire logic [7:0] mode_hi,
   input wire logic [7:0] mode_lo,
   input wire logic rd_clr,
   output logic [7:0] trig,
   output logic [7:0] status_q
);

   logic [7:0] prev_q;
   logic [7:0] status_d;

   function automatic logic fire(input logic hi, input logic lo, input logic cur,
                                 input logic prv);
      case (aeil_trig_t'({hi, lo}))
         AEIL_TRIG_RISE: fire = cur & ~prv;
         AEIL_TRIG_FALL: fire = ~cur & prv;
         AEIL_TRIG_LEVEL: fire = cur;
         default: fire = 1'b0;
      endcase
   endfunction

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         trig[i] = mask[i] & fire(mode_hi[i], mode_lo[i], src[i], prev_q[i]);
      end
      status_d = ((status_q & ~{8{rd_clr}}) | trig) & mask;
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         prev_q <= AEIL_REG_RESET;
      end else begin
         prev_q <= src;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         status_q <= AEIL_REG_RESET;
      end else begin
         status_q <= status_d;
      end
   end

endmodule

/* aeil_tb_top.sv */
// testbench: event stimulus and host reads, one task per scenario
// assumes aeil_top and aeil_host compiled alongside
`timescale 1ns/1ns
module aeil_tb_top
   import aeil_pkg::*;
;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   aeil_req_t reg_req;
   logic [7:0] reg_rdata_q, d;
   logic interrupt_q, mtk = 1'b0, ftk = 1'b0, fv = 1'b0;
   logic [13:0] ev = '0;
   logic [7:0] cf = '0;
   logic [1:0] sel = 2'h0;
   logic [15:0] fi = 16'h0000, fo = 16'h0000;
   int n_fail = 0, n_compared = 0, fper = 0, cnt = 0;
   always #20 ref_clk = ~ref_clk;
   // ********
   // frame and master ticks
   // ********
   always @(negedge ref_clk) begin
      mtk <= (fper != 0);
      cnt <= (cnt >= fper - 1) ? 0 : cnt + 1;
      ftk <= (fper != 0) && (cnt == 0);
   end
   aeil_host aeil_host_i (.ref_clk(ref_clk), .reg_rdata_q(reg_rdata_q), .reg_req(reg_req));
   aeil_top aeil_top_i (
      .ref_clk(ref_clk), .rst_b(rst_b), .reg_req(reg_req), .reg_rdata_q(reg_rdata_q),
      .interrupt_q(interrupt_q), .tx_sample_slip(ev[5]), .tx_path_bypasses_src(cf[0]),
      .tx_source_async(cf[1]), .transmit_block_start_is_input(cf[2]),
      .transmit_block_start_new(ev[6]), .src_in_use(cf[3]), .out_port_sample_slip(ev[7]),
      .out_port_slave(cf[4]), .output_frame_clock_async(cf[5]), .src_feeds_out_port(cf[6]),
      .output_master_clock_tick(mtk), .output_frame_clock_tick(ftk),
      .master_ratio_select(sel), .fs_in_period(fi), .fs_out_period(fo), .fs_periods_valid(fv),
      .left_overrange(ev[4]), .right_overrange(ev[3]), .cstat_d_to_e_busy(ev[2]),
      .cstat_e_to_f_busy(ev[1]), .receiver_error(ev[0]), .varispeed_overflow(ev[13]),
      .converter_tracking(ev[12]), .user_d_to_e_busy(ev[11]), .user_e_to_f_busy(ev[10]),
      .user_block_mode(cf[7]), .subcode_block_ready(ev[9]), .user_fifo_overwrite(ev[8]));
   // ********
   // shared tasks
   // ********
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      aeil_host_i.rd(a, d);
      chk(d, e);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      aeil_host_i.wr(a, v);
   endtask
   task automatic put(input logic [13:0] m, input bit hold);
      @(negedge ref_clk);
      ev = m;
      if (!hold) begin
         @(negedge ref_clk);
         ev = '0;
      end
      repeat (2) @(negedge ref_clk);
   endtask
   task automatic end_of_test();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ********
   // scenarios
   // ********
   task automatic t_regs();
      for (int a = 7; a <= 14; a++) begin
         rc(8'(a), AEIL_REG_RESET);
      end
      rc(8'h20, AEIL_UNMAPPED_READ);
      wr(AEIL_MASK1_ADDR, 8'hFF);
      rc(AEIL_MASK1_ADDR, 8'hFF);
      wr(AEIL_MASK2_ADDR, 8'hFF);
      rc(AEIL_MASK2_ADDR, AEIL_SET2_USED);
      wr(AEIL_STAT1_ADDR, 8'hFF);
      rc(AEIL_STAT1_ADDR, 8'h00);
      $display("test regs done");
   endtask
   task automatic t_rise_mask();
      put(14'h0001, 0);
      chk({7'h00, interrupt_q}, 8'h01);
      rc(AEIL_STAT1_ADDR, 8'h01);
      rc(AEIL_STAT1_ADDR, 8'h00);
      chk({7'h00, interrupt_q}, 8'h00);
      wr(AEIL_MASK1_ADDR, 8'hFE);
      put(14'h0001, 0);
      chk({7'h00, interrupt_q}, 8'h00);
      rc(AEIL_STAT1_ADDR, 8'h00);
      wr(AEIL_MASK1_ADDR, 8'hFF);
      $display("test rise_mask done");
   endtask
   task automatic t_modes();
      wr(AEIL_MODE1_LO_ADDR, 8'h10);
      put(14'h0010, 1);
      rc(AEIL_STAT1_ADDR, 8'h00);
      put(14'h0000, 1);
      rc(AEIL_STAT1_ADDR, 8'h10);
      wr(AEIL_MODE1_LO_ADDR, 8'h00);
      wr(AEIL_MODE1_HI_ADDR, 8'h08);
      put(14'h0008, 1);
      rc(AEIL_STAT1_ADDR, 8'h08);
      rc(AEIL_STAT1_ADDR, 8'h08);
      put(14'h0000, 1);
      rc(AEIL_STAT1_ADDR, 8'h08);
      rc(AEIL_STAT1_ADDR, 8'h00);
      wr(AEIL_MODE1_HI_ADDR, 8'h04);
      wr(AEIL_MODE1_LO_ADDR, 8'h04);
      put(14'h0004, 0);
      chk({7'h00, interrupt_q}, 8'h00);
      rc(AEIL_STAT1_ADDR, 8'h00);
      wr(AEIL_MODE1_HI_ADDR, 8'h00);
      wr(AEIL_MODE1_LO_ADDR, 8'h00);
      put(14'h001E, 0);
      rc(AEIL_STAT1_ADDR, 8'h1E);
      $display("test modes done");
   endtask
   task automatic t_sources();
      cf = 8'h03;
      put(14'h0020, 0);
      rc(AEIL_STAT1_ADDR, 8'h80);
      cf = 8'h04;
      put(14'h0040, 0);
      rc(AEIL_STAT1_ADDR, 8'h80);
      cf = 8'h30;
      put(14'h0080, 0);
      rc(AEIL_STAT1_ADDR, 8'h40);
      cf = 8'h08;
      put(14'h00E0, 0);
      rc(AEIL_STAT1_ADDR, 8'h00);
      cf = 8'h00;
      put(14'h3F00, 0);
      rc(AEIL_STAT2_ADDR, 8'h33);
      cf = 8'h80;
      put(14'h0C00, 0);
      rc(AEIL_STAT2_ADDR, 8'h0C);
      cf = 8'h00;
      $display("test sources done");
   endtask
   task automatic t_range();
      fi = 16'h012C;
      fo = 16'h0064;
      fv = 1'b1;
      rc(AEIL_STAT1_ADDR, 8'h00);
      fi = 16'h012D;
      rc(AEIL_STAT1_ADDR, 8'h20);
      rc(AEIL_STAT1_ADDR, 8'h00);
      fv = 1'b0;
      fi = 16'h0064;
      fo = 16'h012D;
      rc(AEIL_STAT1_ADDR, 8'h00);
      fv = 1'b1;
      rc(AEIL_STAT1_ADDR, 8'h20);
      rc(AEIL_STAT1_ADDR, 8'h00);
      fv = 1'b0;
      $display("test range done");
   endtask
   task automatic t_ratio(input logic [1:0] s, input int p, input logic [7:0] e);
      cf = 8'h58;
      sel = s;
      fper = p;
      repeat (1100) @(negedge ref_clk);
      aeil_host_i.rd(AEIL_STAT1_ADDR, d);
      repeat (1100) @(negedge ref_clk);
      rc(AEIL_STAT1_ADDR, e);
      $display("test ratio done");
   endtask
   task automatic t_reset();
      wr(AEIL_MODE2_HI_ADDR, 8'h21);
      @(negedge ref_clk);
      rst_b = 1'b0;
      repeat (2) @(negedge ref_clk);
      rst_b = 1'b1;
      rc(AEIL_MASK1_ADDR, AEIL_REG_RESET);
      rc(AEIL_MODE2_HI_ADDR, AEIL_REG_RESET);
      chk({7'h00, interrupt_q}, 8'h00);
      $display("test reset done");
   endtask
   initial begin
      repeat (16) @(negedge ref_clk);
      rst_b = 1'b1;
      t_regs();
      t_rise_mask();
      t_modes();
      t_sources();
      t_range();
      t_ratio(2'h0, 256, 8'h00);
      t_ratio(2'h1, 256, 8'h40);
      t_ratio(2'h1, 384, 8'h00);
      t_ratio(2'h2, 512, 8'h00);
      t_ratio(2'h3, 300, 8'h00);
      t_reset();
      end_of_test();
   end
   initial begin
      #800000;
      n_fail++;
      end_of_test();
   end
endmodule

/* aeil_top.sv */
// event collection, sticky status, masks, trigger modes and the interrupt output
// assumes all event inputs are ref_clk-domain pulses or levels from device logic
`timescale 1ns/1ns

// Contract
// - status bit is 1 if its event occurred since last read, else 0.
// - reading status clears it, except level-mode bits whose source persists.
// - a status bit with its mask bit clear always reads 0.
// - status, mask and mode registers reset to 00.
// - mask 1 lets event reach status and interrupt; mask 0 blocks both.
// - mask bits sit at the same positions as their status bits.
// - two-bit mode from high and low registers: rise, fall, level, reserved.
// - rise fires on appearance, fall on removal, level while present.
// - transmit slip fires on each slip in bypass path with asynchronous source.
// - transmit slip also fires on new block start when input and converter unused.
// - output slip fires on each slip when slave port with asynchronous frame clock.
// - output slip flags master-to-frame ratio mismatch when converter feeds slave port.
// - range event fires when either rate ratio exceeds three.
// - left and right over-range events fire.
// - channel status transfer sources true during each buffer transfer.
// - receiver fault event fires on receiver error; type read elsewhere.
// - varispeed event fires when converter buffer overflows.
// - tracking event fires while converter follows a changing rate.
// - user transfer sources true during transfers, only in block mode.
// - user FIFO overwrite event fires on every overwrite.
// - ratio selection 00=256, 01=384, 10=512, 11 reserved.
module aeil_top
   import aeil_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire aeil_req_t reg_req,
   output logic [7:0] reg_rdata_q,
   output logic interrupt_q,
   input wire logic tx_sample_slip,
   input wire logic tx_path_bypasses_src,
   input wire logic tx_source_async,
   input wire logic transmit_block_start_is_input,
   input wire logic transmit_block_start_new,
   input wire logic src_in_use,
   input wire logic out_port_sample_slip,
   input wire logic out_port_slave,
   input wire logic output_frame_clock_async,
   input wire logic src_feeds_out_port,
   input wire logic output_master_clock_tick,
   input wire logic output_frame_clock_tick,
   input wire logic [1:0] master_ratio_select,
   input wire logic [15:0] fs_in_period,
   input wire logic [15:0] fs_out_period,
   input wire logic fs_periods_valid,
   input wire logic left_overrange,
   input wire logic right_overrange,
   input wire logic cstat_d_to_e_busy,
   input wire logic cstat_e_to_f_busy,
   input wire logic receiver_error,
   input wire logic varispeed_overflow,
   input wire logic converter_tracking,
   input wire logic user_d_to_e_busy,
   input wire logic user_e_to_f_busy,
   input wire logic user_block_mode,
   input wire logic subcode_block_ready,
   input wire logic user_fifo_overwrite
);

   // ************************************************************
   // declarations
   // ************************************************************
   logic [7:0] mask1_q;
   logic [7:0] mask2_q;
   logic [7:0] mode1_hi_q;
   logic [7:0] mode1_lo_q;
   logic [7:0] mode2_hi_q;
   logic [7:0] mode2_lo_q;
   logic [7:0] stat1;
   logic [7:0] stat2;
   logic [7:0] trig1;
   logic [7:0] trig2;
   logic [7:0] src1;
   logic [7:0] src2;
   logic clr1;
   logic clr2;
   logic ratio_mismatch;
   logic ratio_check_en;
   logic pending;
   logic [7:0] rdata_d;

   logic transmit_path_slip_event;
   logic output_port_slip_event;
   logic ratio_range_exceeded_event;
   logic left_overrange_event;
   logic right_overrange_event;
   logic cstat_d_to_e_event;
   logic cstat_e_to_f_event;
   logic receiver_fault_event;
   logic varispeed_overflow_event;
   logic converter_tracking_event;
   logic user_d_to_e_event;
   logic user_e_to_f_event;
   logic subcode_ready_event;
   logic user_fifo_overwrite_event;

   // true when a exceeds three times b
   function automatic logic over_three(input logic [15:0] a, input logic [15:0] b);
      logic [17:0] wide_b;
      wide_b = {2'h0, b};
      over_three = {2'h0, a} > (wide_b * {16'h0000, AEIL_RANGE_LIMIT});
   endfunction

   // ************************************************************
   // event sources
   // ************************************************************
   // slip in converter bypass, or new input block start with converter unused
   assign transmit_path_slip_event =
      (tx_sample_slip & tx_path_bypasses_src & tx_source_async) |
      (transmit_block_start_is_input & ~src_in_use & transmit_block_start_new);

   assign ratio_check_en = src_in_use & src_feeds_out_port & out_port_slave;

   assign output_port_slip_event =
      (out_port_sample_slip & out_port_slave & output_frame_clock_async) | ratio_mismatch;

   assign ratio_range_exceeded_event = fs_periods_valid &
      (over_three(fs_in_period, fs_out_period) | over_three(fs_out_period, fs_in_period));

   assign left_overrange_event = left_overrange;
   assign right_overrange_event = right_overrange;

   assign cstat_d_to_e_event = cstat_d_to_e_busy;
   assign cstat_e_to_f_event = cstat_e_to_f_busy;

   assign receiver_fault_event = receiver_error;

   assign varispeed_overflow_event = varispeed_overflow;

   assign converter_tracking_event = converter_tracking;

   assign user_d_to_e_event = user_d_to_e_busy & user_block_mode;
   assign user_e_to_f_event = user_e_to_f_busy & user_block_mode;

   assign subcode_ready_event = subcode_block_ready;

   assign user_fifo_overwrite_event = user_fifo_overwrite;

   // same positions as mask and mode bits
   assign src1 = {transmit_path_slip_event, output_port_slip_event,
                  ratio_range_exceeded_event, left_overrange_event, right_overrange_event,
                  cstat_d_to_e_event, cstat_e_to_f_event, receiver_fault_event};
   assign src2 = {2'h0, varispeed_overflow_event, converter_tracking_event,
                  user_d_to_e_event, user_e_to_f_event, subcode_ready_event,
                  user_fifo_overwrite_event};

   aeil_ratio_check u_ratio (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .check_en(ratio_check_en),
      .master_tick(output_master_clock_tick),
      .frame_tick(output_frame_clock_tick),
      .master_ratio_select(master_ratio_select),
      .mismatch_q(ratio_mismatch)
   );

   // ************************************************************
   // status registers
   // ************************************************************
   // read of a status register clears it
   assign clr1 = reg_req.rd & (reg_req.addr == AEIL_STAT1_ADDR);
   assign clr2 = reg_req.rd & (reg_req.addr == AEIL_STAT2_ADDR);

   // high bit from high register, low from low
   aeil_status_reg u_stat1 (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .src(src1),
      .mask(mask1_q),
      .mode_hi(mode1_hi_q),
      .mode_lo(mode1_lo_q),
      .rd_clr(clr1),
      .trig(trig1),
      .status_q(stat1)
   );

   aeil_status_reg u_stat2 (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .src(src2),
      .mask(mask2_q),
      .mode_hi(mode2_hi_q),
      .mode_lo(mode2_lo_q),
      .rd_clr(clr2),
      .trig(trig2),
      .status_q(stat2)
   );

   // ************************************************************
   // control registers
   // ************************************************************
   // all reset to 00
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         mask1_q <= AEIL_REG_RESET;
         mask2_q <= AEIL_REG_RESET;
      end else if (reg_req.wr) begin
         if (reg_req.addr == AEIL_MASK1_ADDR) begin
            mask1_q <= reg_req.wdata;
         end
         if (reg_req.addr == AEIL_MASK2_ADDR) begin
            mask2_q <= reg_req.wdata & AEIL_SET2_USED;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         mode1_hi_q <= AEIL_REG_RESET;
         mode1_lo_q <= AEIL_REG_RESET;
         mode2_hi_q <= AEIL_REG_RESET;
         mode2_lo_q <= AEIL_REG_RESET;
      end else if (reg_req.wr) begin
         case (reg_req.addr)
            AEIL_MODE1_HI_ADDR: mode1_hi_q <= reg_req.wdata;
            AEIL_MODE1_LO_ADDR: mode1_lo_q <= reg_req.wdata;
            AEIL_MODE2_HI_ADDR: mode2_hi_q <= reg_req.wdata & AEIL_SET2_USED;
            AEIL_MODE2_LO_ADDR: mode2_lo_q <= reg_req.wdata & AEIL_SET2_USED;
            default: ;
         endcase
      end
   end

   // ************************************************************
   // read port
   // ************************************************************
   always_comb begin
      case (reg_req.addr)
         AEIL_STAT1_ADDR: rdata_d = stat1 & mask1_q;
         AEIL_STAT2_ADDR: rdata_d = stat2 & mask2_q;
         AEIL_MASK1_ADDR: rdata_d = mask1_q;
         AEIL_MODE1_HI_ADDR: rdata_d = mode1_hi_q;
         AEIL_MODE1_LO_ADDR: rdata_d = mode1_lo_q;
         AEIL_MASK2_ADDR: rdata_d = mask2_q;
         AEIL_MODE2_HI_ADDR: rdata_d = mode2_hi_q;
         AEIL_MODE2_LO_ADDR: rdata_d = mode2_lo_q;
         default: rdata_d = AEIL_UNMAPPED_READ;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata_q <= AEIL_REG_RESET;
      end else if (reg_req.rd) begin
         reg_rdata_q <= rdata_d;
      end
   end

   // ************************************************************
   // interrupt output
   // ************************************************************
   assign pending = |(stat1 & mask1_q) | |(stat2 & mask2_q);

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         interrupt_q <= 1'b0;
      end else begin
         interrupt_q <= pending;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   logic seen_q;
   logic [7:0] lvl1;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         seen_q <= 1'b0;
      end else begin
         seen_q <= 1'b1;
      end
   end

   assign lvl1 = mask1_q & mode1_hi_q & ~mode1_lo_q & src1;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);

   masked_read_zero_a: assert property (
      clr1 |=> (reg_rdata_q & ~$past(mask1_q)) == 8'h00)
      else $error("masked status bit read as one");

   read_clears_a: assert property (
      clr1 && trig1 == 8'h00 |=> stat1 == 8'h00)
      else $error("status not cleared by read");

   status_sticky_a: assert property (
      !clr1 |=> ($past(stat1) & mask1_q & ~stat1) == 8'h00)
      else $error("status bit dropped without read");

   reset_zero_a: assert property (
      !seen_q |-> stat1 == 8'h00 && stat2 == 8'h00 && mask1_q == 8'h00
                  && mode1_hi_q == 8'h00 && mode2_lo_q == 8'h00 && interrupt_q == 1'b0)
      else $error("register not zero after reset");

   trig_sets_a: assert property (
      trig2 != 8'h00 |=> (stat2 & $past(trig2)) == $past(trig2))
      else $error("trigger did not set status");

   int_raise_a: assert property (
      trig1 != 8'h00 |=> ##1 interrupt_q)
      else $error("interrupt missed an unmasked trigger");

   int_drop_a: assert property (
      clr1 && trig1 == 8'h00 && stat2 == 8'h00 && trig2 == 8'h00
         |=> ##1 !interrupt_q)
      else $error("interrupt stuck after clearing reads");

   reserved_silent_a: assert property (
      ((trig1 & mode1_hi_q & mode1_lo_q) | (trig2 & mode2_hi_q & mode2_lo_q)) == 8'h00)
      else $error("reserved trigger mode fired");

   level_hold_a: assert property (
      clr1 && lvl1 != 8'h00 |=> (stat1 & $past(lvl1)) == $past(lvl1))
      else $error("level bit cleared while source present");

   block_start_a: assert property (
      transmit_block_start_is_input && !src_in_use && transmit_block_start_new
         && mask1_q[AEIL_TX_SLIP_BIT] && !mode1_hi_q[AEIL_TX_SLIP_BIT]
         && !mode1_lo_q[AEIL_TX_SLIP_BIT] && !$past(src1[AEIL_TX_SLIP_BIT])
         |=> stat1[AEIL_TX_SLIP_BIT])
      else $error("block start did not flag transmit slip");

   user_block_only_a: assert property (
      !user_block_mode |-> src2[3:2] == 2'h0)
      else $error("user transfer source outside block mode");

   level_held_c: cover property (clr1 && lvl1 != 8'h00 ##1 stat1 != 8'h00);
   int_cycle_c: cover property (!interrupt_q ##1 interrupt_q ##[1:20] !interrupt_q);
   ratio_slip_c: cover property (ratio_mismatch ##1 stat1[AEIL_OUT_SLIP_BIT]);
   fall_mode_c: cover property (trig2 != 8'h00 && mode2_lo_q != 8'h00);

endmodule
